// *** include/compat_pkg.sv ***
// constants, types and the address-map decoder for the legacy-compatibility gating block
// assumes a 32-bit AHB-Lite register window and a 16-bit core data address
package compat_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_RCAUSE = 8'h04;
  localparam logic [7:0] OFF_FEAT   = 8'h08;
  localparam logic [7:0] OFF_ISTAT  = 8'h0c;
  localparam logic [7:0] OFF_IMASK  = 8'h10;
  localparam logic [7:0] OFF_MODE   = 8'h14;

  // control register fields
  localparam int CTRL_XMEM  = 0;
  localparam int CTRL_ASYNC = 1;
  localparam int CTRL_PORTC = 2;
  localparam int CTRL_WDEN  = 3;
  localparam int CTRL_PRE   = 4;
  localparam int CTRL_WDCHG = 7;
  localparam int WD_PRE_W   = 3;
  localparam logic [WD_PRE_W-1:0] WD_PRE_RST = 3'h0;

  // reset-cause register fields
  localparam int RC_POR = 0;
  localparam int RC_EXT = 1;
  localparam int RC_BOD = 2;
  localparam int RC_WDT = 3;
  localparam int RC_TAP = 4;
  localparam int RC_TPD = 7;
  localparam logic [7:0] RC_COMPAT_MASK = 8'h03;
  localparam logic [7:0] RC_FULL_MASK   = 8'h9f;
  localparam logic [7:0] RC_FLAG_MASK   = 8'h1f;

  // interrupt status and mask fields
  localparam int IRQ_WDT = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_SEQ = 2;
  localparam int IRQ_W   = 3;

  // watchdog timing: ticks of the dedicated oscillator, window in bus clocks
  localparam int unsigned WD_OSC_HZ     = 1_000_000;
  localparam logic [2:0]  WD_SEQ_CYCLES = 3'h4;

  // receive occupancy limits
  localparam logic [1:0] RX_DEPTH_COMPAT = 2'h1;
  localparam logic [1:0] RX_DEPTH_NEW    = 2'h2;

  // address map boundaries
  localparam logic [15:0] EXTIO_LO    = 16'h0060;
  localparam logic [15:0] EXTIO_HI    = 16'h00ff;
  localparam logic [15:0] SRAM_LO_NEW = 16'h0100;
  localparam logic [15:0] SRAM_HI_NEW = 16'h10ff;
  localparam logic [15:0] XMEM_NEW    = 16'h1100;
  localparam logic [15:0] XMEM_OLD    = 16'h1000;

  typedef enum logic [1:0] {REG_IO, REG_EXTIO, REG_SRAM, REG_XMEM} region_t;

  typedef struct packed {
    logic compat;
    logic wdt_on;
    logic tap_en;
  } mode_t;

  localparam mode_t MODE_RST = '{compat: 1'b1, wdt_on: 1'b0, tap_en: 1'b0};

  typedef struct packed {
    logic two_wire_port;
    logic serial2;
    logic serial_adv;
    logic self_prog;
    logic xmem_wait;
    logic timer1_cmp3;
    logic timer3;
    logic irq_edge;
    logic rx_fifo;
  } feature_t;

  localparam int FEAT_W = $bits(feature_t);

  typedef struct packed {
    logic tap_pins;
    logic portc_oe_n;
    logic portc_in_ok;
    logic portf_out_ok;
    logic portg_gpio_ok;
    logic strobe_oe_n;
    logic tosc_osc;
  } pins_t;

  localparam pins_t PINS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  // which region a core data address falls in, per memory-map mode
  function automatic region_t addr_region(logic [15:0] a, logic compat);
    if (a < EXTIO_LO) return REG_IO;
    if (compat) return (a < XMEM_OLD) ? REG_SRAM : REG_XMEM;
    if (a <= EXTIO_HI) return REG_EXTIO;
    if (a <= SRAM_HI_NEW) return REG_SRAM;
    return REG_XMEM;
  endfunction

endpackage

// *** rtl/compat_gating.sv ***
// legacy-compatibility fuse gating: feature enables, memory map, pin ownership, watchdog, reset causes
// assumes static fuse inputs, synchronous event strobes and one AHB-Lite master
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
module compat_gating
  import compat_pkg::*;
#(
  parameter int unsigned WD_BASE_TICKS = 16384,
  parameter int unsigned WD_CNT_W      = 22
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             legacy_compat_fuse,
  input  wire logic             watchdog_always_on_fuse,
  input  wire logic             test_port_enable_fuse,
  input  wire logic             por_cause,
  input  wire logic             ext_cause,
  input  wire logic             bod_cause,
  input  wire logic             tap_cause,
  input  wire logic             wd_osc_tick,
  input  wire logic             wd_kick,
  input  wire logic             rx_byte_in,
  input  wire logic             rx_read,
  input  wire logic [15:0]      mem_addr,
  output feature_t              feature_r,
  output pins_t                 pins_r,
  output region_t               region_r,
  output logic                  wd_reset_req_r,
  output logic                  rx_overrun_flag,
  output logic      [1:0]       rx_level_r,
  output logic                  irq_r
);

  // fuse mode, captured once after reset release
  logic        mode_valid_r;
  mode_t       mode_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_valid_r <= 1'b0;
      mode_r       <= MODE_RST;
    end else if (clk_en && !mode_valid_r) begin
      mode_valid_r <= 1'b1;
      mode_r       <= '{compat: legacy_compat_fuse, wdt_on: watchdog_always_on_fuse,
                        tap_en: test_port_enable_fuse};
    end
  end

  wire compat = mode_r.compat;

  // bus slave: writes without wait, reads with one wait state
  logic        ap_wr_r;
  logic        rd_pend_r;
  logic [7:0]  ap_addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic [31:0] rd_mux;
  wire         ap_take = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r     <= 1'b0;
      rd_pend_r   <= 1'b0;
      ap_addr_r   <= 8'h00;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else if (clk_en) begin
      ap_wr_r     <= ap_take & hwrite;
      rd_pend_r   <= ap_take & ~hwrite;
      ap_addr_r   <= ap_take ? haddr[7:0] : ap_addr_r;
      hrdata_r    <= rd_pend_r ? rd_mux : hrdata_r;
      hreadyout_r <= ~(ap_take & ~hwrite);
    end
  end
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0; // constant OKAY

  // write strobes per writable register (feature and mode registers are read-only)
  wire wr_ctrl  = ap_wr_r & (ap_addr_r == OFF_CTRL);
  wire wr_rc    = ap_wr_r & (ap_addr_r == OFF_RCAUSE);
  wire wr_istat = ap_wr_r & (ap_addr_r == OFF_ISTAT);
  wire wr_imask = ap_wr_r & (ap_addr_r == OFF_IMASK);

  // control register and the watchdog change sequence
  logic                xmem_en_r;
  logic                async_sel_r;
  logic                portc_drv_r;
  logic                wd_en_r;
  logic [WD_PRE_W-1:0] wd_pre_r;
  logic [2:0]          seq_cnt_r;
  wire                 w_chg      = hwdata[CTRL_WDCHG];
  wire                 w_en       = hwdata[CTRL_WDEN];
  wire [WD_PRE_W-1:0]  w_pre      = hwdata[CTRL_PRE +: WD_PRE_W];
  wire                 timed_mode = ~compat | mode_r.wdt_on;
  wire                 seq_open   = seq_cnt_r != 3'h0;
  wire                 seq_start  = wr_ctrl & w_chg & timed_mode;
  wire                 wd_apply   = wr_ctrl & (timed_mode ? (~w_chg & seq_open) : 1'b1);
  wire                 wd_reject  = wr_ctrl & timed_mode & ~w_chg & ~seq_open
                                    & ((w_en != wd_en_r) | (w_pre != wd_pre_r));
  wire                 wd_run     = wd_en_r | mode_r.wdt_on;
  wire [2:0]           seq_cnt_nxt = seq_start ? WD_SEQ_CYCLES :
                                     (wd_apply | ~seq_open) ? 3'h0 : seq_cnt_r - 3'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xmem_en_r   <= 1'b0;
      async_sel_r <= 1'b0;
      portc_drv_r <= 1'b0;
      wd_en_r     <= 1'b0;
      wd_pre_r    <= WD_PRE_RST;
      seq_cnt_r   <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        xmem_en_r   <= hwdata[CTRL_XMEM];
        async_sel_r <= hwdata[CTRL_ASYNC];
        portc_drv_r <= hwdata[CTRL_PORTC];
      end
      if (wd_apply) begin
        wd_en_r  <= w_en;
        wd_pre_r <= w_pre;
      end
      seq_cnt_r <= seq_cnt_nxt;
    end
  end

  // watchdog counter on oscillator ticks
  logic [WD_CNT_W-1:0] wd_cnt_r;
  wire  [WD_CNT_W-1:0] wd_limit = WD_CNT_W'(WD_BASE_TICKS) << wd_pre_r;
  wire                 wd_hit   = wd_run & wd_osc_tick & (wd_cnt_r >= wd_limit - WD_CNT_W'(1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_r       <= '0;
      wd_reset_req_r <= 1'b0;
    end else if (clk_en) begin
      if (!wd_run || wd_kick || wd_hit) wd_cnt_r <= '0;
      else if (wd_osc_tick) wd_cnt_r <= wd_cnt_r + WD_CNT_W'(1);
      wd_reset_req_r <= wd_hit;
    end
  end

  // receive occupancy and overrun
  logic       rx_ovr_r;
  wire  [1:0] rx_cap    = compat ? RX_DEPTH_COMPAT : RX_DEPTH_NEW;
  wire        rx_dec    = rx_read & (rx_level_r != 2'h0);
  wire        rx_ovr_ev = rx_byte_in & (rx_level_r == rx_cap) & ~rx_read;
  wire        rx_inc    = rx_byte_in & ~rx_ovr_ev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_level_r <= 2'h0;
      rx_ovr_r   <= 1'b0;
    end else if (clk_en) begin
      rx_level_r <= rx_level_r + {1'b0, rx_inc} - {1'b0, rx_dec};
      rx_ovr_r   <= rx_ovr_ev | (rx_ovr_r & ~rx_read);
    end
  end
  assign rx_overrun_flag = rx_ovr_r;

  // reset-cause register: flags write-one-to-clear, disable bit plain
  logic [7:0] rcause_r;
  wire  [7:0] rc_mask = compat ? RC_COMPAT_MASK : RC_FULL_MASK;
  wire  [7:0] rc_raw  = {3'h0, tap_cause, wd_hit, bod_cause, ext_cause, por_cause};
  wire  [7:0] rc_set  = rc_raw & rc_mask & RC_FLAG_MASK;
  wire  [7:0] rc_clr  = wr_rc ? (hwdata[7:0] & rc_mask & RC_FLAG_MASK) : 8'h00;
  wire        tpd_nxt = (wr_rc & ~compat) ? hwdata[RC_TPD] : rcause_r[RC_TPD];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rcause_r <= 8'h00;
    else if (clk_en) begin
      rcause_r         <= (rcause_r & ~rc_clr) | rc_set;
      rcause_r[RC_TPD] <= tpd_nxt;
    end
  end

  // interrupt status, mask and line
  logic [IRQ_W-1:0] istat_r;
  logic [IRQ_W-1:0] imask_r;
  wire  [IRQ_W-1:0] ev     = {wd_reject, rx_ovr_ev, wd_hit};
  wire  [IRQ_W-1:0] is_clr = wr_istat ? hwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r   <= 1'b0;
    end else if (clk_en) begin
      istat_r <= (istat_r & ~is_clr) | ev; // set wins over clear
      imask_r <= wr_imask ? hwdata[IRQ_W-1:0] : imask_r;
      irq_r   <= |(istat_r & imask_r);
    end
  end

  // feature gating, pin ownership and address map outputs
  wire pins_t pins_nxt = '{
    tap_pins:      mode_r.tap_en & ~rcause_r[RC_TPD],
    portc_oe_n:    ~(compat | portc_drv_r),
    portc_in_ok:   ~compat,
    portf_out_ok:  ~compat,
    portg_gpio_ok: ~compat,
    strobe_oe_n:   ~(compat | xmem_en_r),
    tosc_osc:      compat | async_sel_r
  };
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feature_r <= '0;
      pins_r    <= PINS_RST;
      region_r  <= REG_IO;
    end else if (clk_en) begin
      feature_r <= feature_t'({FEAT_W{~compat}});
      pins_r    <= pins_nxt;
      region_r  <= addr_region(mem_addr, compat);
    end
  end

  // read data select
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ap_addr_r == OFF_CTRL) begin
      rd_mux[CTRL_XMEM]                 = xmem_en_r;
      rd_mux[CTRL_ASYNC]                = async_sel_r;
      rd_mux[CTRL_PORTC]                = portc_drv_r;
      rd_mux[CTRL_WDEN]                 = wd_en_r;
      rd_mux[CTRL_PRE +: WD_PRE_W]      = wd_pre_r;
    end else if (ap_addr_r == OFF_RCAUSE) begin
      rd_mux[7:0] = rcause_r & rc_mask;
    end else if (ap_addr_r == OFF_FEAT) begin
      rd_mux[FEAT_W-1:0] = feature_r;
    end else if (ap_addr_r == OFF_ISTAT) begin
      rd_mux[IRQ_W-1:0] = istat_r;
    end else if (ap_addr_r == OFF_IMASK) begin
      rd_mux[IRQ_W-1:0] = imask_r;
    end else if (ap_addr_r == OFF_MODE) begin
      rd_mux[3:0] = {pins_r.tap_pins, mode_r.wdt_on, compat, mode_valid_r};
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_mode_hold;
    mode_valid_r |=> mode_r == $past(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");

  property p_compat_feat;
    clk_en && compat && mode_valid_r |=> feature_r == '0;
  endproperty
  a_compat_feat: assert property (p_compat_feat) else $error("feature left on in compat");

  property p_compat_rc;
    compat |-> rcause_r[RC_TPD:RC_BOD] == '0;
  endproperty
  a_compat_rc: assert property (p_compat_rc) else $error("blocked reset-cause bit set");

  property p_rc_full;
    clk_en && !compat && bod_cause |=> rcause_r[RC_BOD];
  endproperty
  a_rc_full: assert property (p_rc_full) else $error("brown-out flag lost");

  property p_tap_pins;
    clk_en && mode_valid_r && compat |=> pins_r.tap_pins == mode_r.tap_en;
  endproperty
  a_tap_pins: assert property (p_tap_pins) else $error("test-port pin ownership wrong");

  sequence s_bad_change;
    clk_en && wr_ctrl && !compat && !seq_open && !w_chg && (w_pre != wd_pre_r);
  endsequence
  property p_seq_reject;
    s_bad_change |=> $stable(wd_pre_r) ##1 istat_r[IRQ_SEQ];
  endproperty
  a_seq_reject: assert property (p_seq_reject) else $error("unsequenced prescaler change taken");

  property p_direct;
    clk_en && wr_ctrl && compat && !mode_r.wdt_on |=> wd_en_r == $past(hwdata[CTRL_WDEN]);
  endproperty
  a_direct: assert property (p_direct) else $error("legacy watchdog write not taken");

  property p_level2;
    clk_en && mode_valid_r && mode_r.wdt_on && !wd_en_r && wd_osc_tick && !wd_kick && !wd_hit
      |=> wd_cnt_r == $past(wd_cnt_r) + WD_CNT_W'(1);
  endproperty
  a_level2: assert property (p_level2) else $error("always-on watchdog stopped");

  property p_timeout;
    clk_en && wd_run && wd_osc_tick && !wd_kick && wd_cnt_r == wd_limit - WD_CNT_W'(1) |=> wd_reset_req_r;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out not raised on last tick");

  property p_extio;
    clk_en && !compat && mem_addr >= EXTIO_LO && mem_addr <= EXTIO_HI |=> region_r == REG_EXTIO;
  endproperty
  a_extio: assert property (p_extio) else $error("extended I/O decode wrong");

  property p_xmem;
    clk_en && !compat && mem_addr >= SRAM_LO_NEW
      |=> region_r == ($past(mem_addr) >= XMEM_NEW ? REG_XMEM : REG_SRAM);
  endproperty
  a_xmem: assert property (p_xmem) else $error("native SRAM or external decode wrong");

  property p_native_pins;
    clk_en && !compat && !portc_drv_r && !xmem_en_r && !async_sel_r
      |=> pins_r.portc_oe_n && pins_r.strobe_oe_n && !pins_r.tosc_osc;
  endproperty
  a_native_pins: assert property (p_native_pins) else $error("native pin default wrong");

  property p_compat_ports;
    clk_en && compat |=> !pins_r.portc_oe_n && !pins_r.portc_in_ok && !pins_r.portg_gpio_ok;
  endproperty
  a_compat_ports: assert property (p_compat_ports) else $error("compat port use wrong");

  property p_overrun;
    clk_en && rx_byte_in && !rx_read && rx_level_r == rx_cap |=> rx_overrun_flag ##0 $stable(rx_level_r);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged at capacity");

  property p_compat_depth;
    compat |-> rx_level_r <= RX_DEPTH_COMPAT;
  endproperty
  a_compat_depth: assert property (p_compat_depth) else $error("receive FIFO active in compat");

  // legacy map: external memory from the old boundary
  property p_compat_map;
    clk_en && compat && mem_addr >= EXTIO_LO
      |=> region_r == (($past(mem_addr) < XMEM_OLD) ? REG_SRAM : REG_XMEM);
  endproperty
  a_compat_map: assert property (p_compat_map) else $error("legacy map decode wrong");

  // native test-port pins follow fuse and disable bit
  property p_tap_native;
    clk_en && mode_valid_r && !compat |=> pins_r.tap_pins == (mode_r.tap_en && !$past(rcause_r[RC_TPD]));
  endproperty
  a_tap_native: assert property (p_tap_native) else $error("native test-port pin ownership wrong");

  // native strobes driven once external memory is on
  property p_strobe;
    clk_en && !compat && xmem_en_r |=> !pins_r.strobe_oe_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobes not driven with external memory");

  // native oscillator pins switch after the select bit
  property p_tosc;
    clk_en && !compat && async_sel_r |=> pins_r.tosc_osc;
  endproperty
  a_tosc: assert property (p_tosc) else $error("oscillator pins not switched");

  // a refused watchdog write always leaves its status bit
  property p_reject_flag;
    clk_en && wd_reject |=> istat_r[IRQ_SEQ];
  endproperty
  a_reject_flag: assert property (p_reject_flag) else $error("refused write not flagged");

  // interrupt line follows unmasked status one edge later
  property p_irq_level;
    clk_en |=> irq_r == (|$past(istat_r & imask_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");

  // every read inserts one wait state
  property p_rd_wait;
    clk_en && ap_take && !hwrite |=> !hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state missing");

endmodule

// *** sim/compat_gating_tb.sv ***
// self-checking bench for the legacy-compatibility gating block
// assumes one ahb-lite master (this bench); fuses are static between resets except one compat-fuse flip late in the native test
module compat_gating_tb import compat_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk, hresetn, hsel, hwrite, clk_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, rx_level_r;
  logic [2:0]  hsize;
  logic        hready, hreadyout, hresp;
  logic        legacy_compat_fuse, watchdog_always_on_fuse, test_port_enable_fuse;
  logic        por_cause, ext_cause, bod_cause, tap_cause;
  logic        wd_osc_tick, wd_kick, rx_byte_in, rx_read;
  logic [15:0] mem_addr;
  feature_t    feature_r;
  pins_t       pins_r;
  region_t     region_r;
  logic        wd_reset_req_r, rx_overrun_flag, irq_r;
  logic [31:0] rd;
  int          err_total, n_checks, nt;

  assign hready = hreadyout;

  compat_gating #(.WD_BASE_TICKS(8), .WD_CNT_W(22)) uut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .legacy_compat_fuse(legacy_compat_fuse),
    .watchdog_always_on_fuse(watchdog_always_on_fuse), .test_port_enable_fuse(test_port_enable_fuse),
    .por_cause(por_cause), .ext_cause(ext_cause), .bod_cause(bod_cause), .tap_cause(tap_cause),
    .wd_osc_tick(wd_osc_tick), .wd_kick(wd_kick), .rx_byte_in(rx_byte_in), .rx_read(rx_read),
    .mem_addr(mem_addr), .feature_r(feature_r), .pins_r(pins_r), .region_r(region_r),
    .wd_reset_req_r(wd_reset_req_r), .rx_overrun_flag(rx_overrun_flag), .rx_level_r(rx_level_r),
    .irq_r(irq_r)
  );

  // 40 mhz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // single word write, waits on hready in both phases
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge hclk iff hreadyout === 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout === 1'b1);
  endtask

  // single word read, data taken at the data-phase ready edge
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge hclk iff hreadyout === 1'b1);
    htrans <= 2'h0;
    @(posedge hclk iff hreadyout === 1'b1);
    d = hrdata;
  endtask

  // reset with a given fuse setting, then let the mode settle
  task automatic do_reset(input logic c, input logic w, input logic t);
    hresetn <= 1'b0;
    legacy_compat_fuse <= c;
    watchdog_always_on_fuse <= w;
    test_port_enable_fuse <= t;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  // pulse the four reset-cause inputs once (por, ext, bod, tap)
  task automatic pulse_causes();
    {por_cause, ext_cause, bod_cause, tap_cause} <= 4'hf;
    @(posedge hclk);
    {por_cause, ext_cause, bod_cause, tap_cause} <= 4'h0;
    repeat (2) @(posedge hclk);
  endtask

  // oscillator ticks four clocks apart until the time-out pulse shows
  task automatic wd_run(output int n);
    n = 0;
    for (int i = 1; i <= 12 && n == 0; i++) begin
      wd_osc_tick <= 1'b1;
      @(posedge hclk);
      wd_osc_tick <= 1'b0;
      repeat (3) begin
        @(posedge hclk);
        if (wd_reset_req_r === 1'b1) n = i;
      end
    end
  endtask

  task automatic rx_push();
    rx_byte_in <= 1'b1;
    @(posedge hclk);
    rx_byte_in <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  task automatic map_chk(input logic [15:0] a, input region_t r);
    mem_addr <= a;
    repeat (2) @(posedge hclk);
    check({30'h0, region_r}, {30'h0, r});
  endtask

  // compatibility mode: gating, pins, map, reset causes, legacy watchdog, receiver
  task automatic t_compat();
    do_reset(1'b1, 1'b0, 1'b1);
    check({23'h0, feature_r}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    ahb_rd(OFF_MODE, rd);
    check(rd, 32'h0b);
    check({31'h0, pins_r.tap_pins}, 32'h1);
    check({28'h0, pins_r.portc_oe_n, pins_r.portc_in_ok, pins_r.portf_out_ok, pins_r.portg_gpio_ok}, 32'h0);
    map_chk(16'h0080, REG_SRAM);
    map_chk(16'h0fff, REG_SRAM);
    map_chk(16'h1000, REG_XMEM);
    ahb_wr(OFF_CTRL, 32'h08);
    ahb_rd(OFF_CTRL, rd);
    check(rd, 32'h08);
    wd_run(nt);
    check(32'(nt), 32'h8);
    ahb_rd(OFF_ISTAT, rd);
    check(rd, 32'h1);
    check({31'h0, irq_r}, 32'h0);
    pulse_causes();
    ahb_rd(OFF_RCAUSE, rd);
    check(rd, 32'h03);
    ahb_wr(OFF_RCAUSE, 32'h9c);
    ahb_rd(OFF_RCAUSE, rd);
    check(rd, 32'h03);
    rx_push();
    check({30'h0, rx_level_r}, 32'h1);
    check({31'h0, rx_overrun_flag}, 32'h0);
    rx_push();
    check({29'h0, rx_overrun_flag, rx_level_r}, 32'h5);
    $display("compat test done");
  endtask

  // native mode: map, pins after reset, reset causes, timed watchdog sequence, interrupt
  task automatic t_native();
    do_reset(1'b0, 1'b0, 1'b1);
    check({23'h0, feature_r}, 32'h1ff);
    check({30'h0, pins_r.portc_oe_n, pins_r.strobe_oe_n}, 32'h3);
    check({31'h0, pins_r.tosc_osc}, 32'h0);
    map_chk(16'h005f, REG_IO);
    map_chk(16'h0060, REG_EXTIO);
    map_chk(16'h00ff, REG_EXTIO);
    map_chk(16'h0100, REG_SRAM);
    map_chk(16'h10ff, REG_SRAM);
    map_chk(16'h1100, REG_XMEM);
    ahb_wr(OFF_CTRL, 32'h07);
    repeat (2) @(posedge hclk);
    check({29'h0, pins_r.portc_oe_n, pins_r.strobe_oe_n, pins_r.tosc_osc}, 32'h1);
    pulse_causes();
    ahb_rd(OFF_RCAUSE, rd);
    check(rd, 32'h17);
    ahb_wr(OFF_RCAUSE, 32'h97);
    ahb_rd(OFF_RCAUSE, rd);
    check(rd, 32'h80);
    repeat (2) @(posedge hclk);
    check({31'h0, pins_r.tap_pins}, 32'h0);
    ahb_wr(OFF_IMASK, 32'h4);
    ahb_wr(OFF_CTRL, 32'h0f);
    repeat (3) @(posedge hclk);
    ahb_rd(OFF_CTRL, rd);
    check(rd, 32'h07);
    check({31'h0, irq_r}, 32'h1);
    ahb_wr(OFF_ISTAT, 32'h4);
    repeat (3) @(posedge hclk);
    check({31'h0, irq_r}, 32'h0);
    ahb_wr(OFF_CTRL, 32'h87);
    ahb_wr(OFF_CTRL, 32'h0f);
    ahb_rd(OFF_CTRL, rd);
    check(rd, 32'h0f);
    ahb_wr(OFF_CTRL, 32'h1f);
    ahb_rd(OFF_CTRL, rd);
    check(rd, 32'h0f);
    ahb_rd(OFF_ISTAT, rd);
    check(rd, 32'h4);
    ahb_wr(OFF_FEAT, 32'h0);
    ahb_rd(OFF_FEAT, rd);
    check(rd, 32'h1ff);
    ahb_rd(8'h18, rd);
    check(rd, 32'h0);
    rx_push();
    rx_push();
    check({29'h0, rx_overrun_flag, rx_level_r}, 32'h2);
    rx_push();
    check({29'h0, rx_overrun_flag, rx_level_r}, 32'h6);
    rx_read <= 1'b1;
    @(posedge hclk);
    rx_read <= 1'b0;
    repeat (2) @(posedge hclk);
    check({29'h0, rx_overrun_flag, rx_level_r}, 32'h1);
    legacy_compat_fuse <= 1'b1;
    repeat (4) @(posedge hclk);
    check({23'h0, feature_r}, 32'h1ff);
    $display("native test done");
  endtask

  // always-on level: runs with the enable clear, test port released
  task automatic t_always_on();
    do_reset(1'b1, 1'b1, 1'b0);
    ahb_rd(OFF_MODE, rd);
    check(rd, 32'h07);
    check({31'h0, pins_r.tap_pins}, 32'h0);
    wd_run(nt);
    check(32'(nt), 32'h8);
    $display("always-on test done");
  endtask

  // main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    clk_en = 1'b1;
    hsize = 3'h2;
    {legacy_compat_fuse, watchdog_always_on_fuse, test_port_enable_fuse} = 3'h4;
    {por_cause, ext_cause, bod_cause, tap_cause, wd_osc_tick, wd_kick, rx_byte_in, rx_read} = '0;
    mem_addr = 16'h0;
    @(posedge hclk);
    t_compat();
    t_native();
    t_always_on();
    summarize();
  end

  // hang guard, well past the few hundred cycles the tests need
  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule
